/* src/dvm_host_ctrl.sv */
/*
  Maintenance message issuer: software fills message fields over an
  Avalon-MM slave with waitrequest, then writes go; the message leaves
  on the read address channel as one or two beats.
  Assumes a single clock, synchronous inputs and a receiver that keeps
  the valid/ready handshake of the read address channel.
*/
`timescale 1ns/1ns
`include "dvm_defines.svh"

// Contract
// RULE1 - bit 5 marks byte 23:16 valid; clear means zero except hint
// RULE2 - bit 4 chooses all translations or leaf entry only
// RULE3 - bits 3:2 stage: 00 both, 01 stage 1, 10 stage 2, 11 reserved
// RULE4 - receiver of oldest version derives stage from invalidation type
// RULE5 - bit 0 set means address follows in a second part
// RULE6 - sender drives every unused address bit to zero
// RULE7 - second part high bits carry the va or pa layout, bit 3 va 40
// RULE8 - second part bits 11:4 low address or range fields
// RULE9 - range data only with range version and tlbi by ipa or va
// RULE10 - first part bit 7 marks a range message
// RULE11 - bits 11:10 granule code: none, 4KB, 16KB, 64KB
// RULE12 - bits 9:8 leaf level hint, 00 means no hint
// RULE13 - bits 7:6 range exponent constant
// RULE14 - five bit multiplier split over bits 5:4 and 2:0
// RULE15 - fields ride on read address plus four bit vmid extension
// RULE16 - bits 14:12 message type, 101 and 111 reserved
// RULE17 - bit 15 asks for a completion transaction
// RULE18 - bit 6 marks bits 31:24 and extension valid, else zero; code keeps both for hint messages too
// RULE19 - bit 1 driven zero, reserved stage treated as unsupported
module dvm_host_ctrl (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_ar_valid,
    output logic [47:0] o_ar_addr,
    output logic [3:0] o_ar_vmidext,
    input wire logic i_ar_ready,
    output logic o_busy
);
    dvm_msg_if msg ();

    // ==========================================================
    // register storage
    logic [31:0] msg_lo_reg;
    logic [19:0] msg_hi_reg;
    logic [31:0] addr_lo_reg;
    logic [20:0] addr_hi_reg;
    logic [15:0] range_reg;
    logic [1:0] version_reg;
    logic err_stage_reg;
    logic err_type_reg;
    logic [31:0] count_reg;
    logic [31:0] last_p1_reg;
    logic [31:0] last_p2_reg;
    logic rd_ack_reg;
    logic [31:0] rd_data_reg;

    // ==========================================================
    // bus decode
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] idx);
        hit = (addr == idx);
    endfunction

    wire wr_ctrl = i_avs_write & hit(i_avs_address, `REG_CTRL);
    wire wr_lo = i_avs_write & hit(i_avs_address, `REG_MSG_LO);
    wire wr_hi = i_avs_write & hit(i_avs_address, `REG_MSG_HI);
    wire wr_alo = i_avs_write & hit(i_avs_address, `REG_ADDR_LO);
    wire wr_ahi = i_avs_write & hit(i_avs_address, `REG_ADDR_HI);
    wire wr_rng = i_avs_write & hit(i_avs_address, `REG_RANGE);
    wire wr_st = i_avs_write & hit(i_avs_address, `REG_STATUS);
    wire go_req = wr_ctrl & i_avs_writedata[`CTRL_GO];

    // a go while a message is on the wire is held off, not dropped
    wire go_stall = go_req & msg.busy;
    wire go_take = go_req & ~msg.busy;
    wire refuse = msg.bad_stage | msg.bad_type;
    wire go_fire = go_take & ~refuse;

    // any field write during a message would only confuse readback
    wire fld_stall = msg.busy & (wr_lo | wr_hi | wr_alo | wr_ahi | wr_rng);

    // reads take one wait cycle so read data comes from a flop
    assign o_avs_waitrequest = (i_avs_read & ~rd_ack_reg) | go_stall | fld_stall;
    wire wr_ok = i_avs_write & ~go_stall & ~fld_stall;

    // ==========================================================
    // version used by a go that also rewrites the control word
    wire [1:0] version_next = wr_ctrl ? i_avs_writedata[`CTRL_VER_LSB +: 2] : version_reg;

    // encoder inputs
    assign msg.msg_lo = msg_lo_reg;
    assign msg.msg_hi = msg_hi_reg;
    assign msg.addr_lo = addr_lo_reg;
    assign msg.addr_hi = addr_hi_reg;
    assign msg.range_cfg = range_reg;
    assign msg.version = dvm_pkg::dvm_version_e'(version_next);
    assign msg.start = go_fire; // RULE19

    dvm_field_encoder u_enc (
        .m(msg.enc)
    );

    dvm_ar_sender u_snd (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .m(msg.snd),
        .o_ar_valid(o_ar_valid),
        .o_ar_addr(o_ar_addr),
        .o_ar_vmidext(o_ar_vmidext),
        .i_ar_ready(i_ar_ready)
    );

    assign o_busy = msg.busy;

    // ==========================================================
    // status word and readback mux
    wire [31:0] status_word = {28'h000_0000, msg_lo_reg[`F_ADDR],
                               err_type_reg, err_stage_reg, msg.busy};
    wire [31:0] ctrl_word = {29'h0000_0000, version_reg, 1'b0};
    logic [31:0] rd_mux;

    always_comb begin
        case (i_avs_address)
            `REG_CTRL: rd_mux = ctrl_word;
            `REG_MSG_LO: rd_mux = msg_lo_reg;
            `REG_MSG_HI: rd_mux = {12'h000, msg_hi_reg};
            `REG_ADDR_LO: rd_mux = addr_lo_reg;
            `REG_ADDR_HI: rd_mux = {11'h000, addr_hi_reg};
            `REG_RANGE: rd_mux = {16'h0000, range_reg};
            `REG_STATUS: rd_mux = status_word;
            `REG_COUNT: rd_mux = count_reg;
            `REG_LAST_P1: rd_mux = last_p1_reg;
            `REG_LAST_P2: rd_mux = last_p2_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    assign o_avs_readdata = rd_data_reg;

    // read strobe: data captured, then waitrequest drops for one cycle
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rd_ack_reg <= 1'b0;
            rd_data_reg <= `REG_RESET;
        end else begin
            rd_ack_reg <= i_avs_read & ~rd_ack_reg;
            if (i_avs_read && !rd_ack_reg)
                rd_data_reg <= rd_mux;
        end
    end

    // ==========================================================
    // message field registers
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            msg_lo_reg <= `REG_RESET;
            msg_hi_reg <= 20'h0_0000;
            addr_lo_reg <= `REG_RESET;
            addr_hi_reg <= 21'h00_0000;
            range_reg <= 16'h0000;
        end else begin
            if (wr_ok && wr_lo)
                msg_lo_reg <= i_avs_writedata; // RULE16 RULE17
            if (wr_ok && wr_hi)
                msg_hi_reg <= i_avs_writedata[19:0];
            if (wr_ok && wr_alo)
                addr_lo_reg <= i_avs_writedata;
            if (wr_ok && wr_ahi)
                addr_hi_reg <= i_avs_writedata[20:0];
            if (wr_ok && wr_rng)
                range_reg <= i_avs_writedata[15:0];
        end
    end

    // ==========================================================
    // control: the message version steers the encoder
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst)
            version_reg <= `VERSION_RESET;
        else if (wr_ok && wr_ctrl)
            version_reg <= version_next;
    end

    // ==========================================================
    // sticky refusal flags, write one to clear; a new refusal wins
    wire set_stage = go_take & msg.bad_stage; // RULE19
    wire set_type = go_take & msg.bad_type;
    wire clr_stage = wr_ok & wr_st & i_avs_writedata[`ST_ERR_STAGE];
    wire clr_type = wr_ok & wr_st & i_avs_writedata[`ST_ERR_TYPE];

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            err_stage_reg <= 1'b0;
            err_type_reg <= 1'b0;
        end else begin
            err_stage_reg <= set_stage | (err_stage_reg & ~clr_stage);
            err_type_reg <= set_type | (err_type_reg & ~clr_type);
        end
    end

    // ==========================================================
    // completed message count and last words sent, for debug readback
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            count_reg <= `REG_RESET;
            last_p1_reg <= `REG_RESET;
            last_p2_reg <= `REG_RESET;
        end else begin
            if (msg.done)
                count_reg <= count_reg + 32'h0000_0001;
            if (go_fire) begin
                last_p1_reg <= msg.part1[31:0];
                last_p2_reg <= msg.part2[31:0];
            end
        end
    end
endmodule

/* src/dvm_defines.svh */
/*
  Register offsets, field positions, codes and reset values for the
  maintenance message issuer. Assumes Avalon word addressing: the
  offsets are word indexes, byte address is four times the index.
*/
`ifndef DVM_DEFINES_SVH
`define DVM_DEFINES_SVH

// ==========================================================
// register word indexes
`define REG_CTRL 4'h0
`define REG_MSG_LO 4'h1
`define REG_MSG_HI 4'h2
`define REG_ADDR_LO 4'h3
`define REG_ADDR_HI 4'h4
`define REG_RANGE 4'h5
`define REG_STATUS 4'h6
`define REG_COUNT 4'h7
`define REG_LAST_P1 4'h8
`define REG_LAST_P2 4'h9

// ==========================================================
// control and status bits
`define CTRL_GO 0
`define CTRL_VER_LSB 1
`define ST_BUSY 0
`define ST_ERR_STAGE 1
`define ST_ERR_TYPE 2
`define ST_TWO_PART 3

// ==========================================================
// first part field positions
`define F_ADDR 0
`define F_STAGE_LSB 2
`define F_LEAF 4
`define F_ASID_V 5
`define F_VMID_V 6
`define F_RANGE 7
`define F_TYPE_LSB 12

// ==========================================================
// range register layout: tg, ttl, scale, num, second part vmid ext
`define RG_TG_LSB 0
`define RG_TTL_LSB 2
`define RG_SCALE_LSB 4
`define RG_NUM_LSB 6
`define RG_EXT_LSB 12

// ==========================================================
// message codes
`define TYPE_TLBI 3'h0
`define TYPE_PICI 3'h2
`define TYPE_HINT 3'h6
`define TYPE_RSV_A 3'h5
`define TYPE_RSV_B 3'h7
`define STAGE_RSV 2'h3

// ==========================================================
// reset values
`define VERSION_RESET 2'h3
`define REG_RESET 32'h0000_0000

`endif

/* src/dvm_pkg.sv */
/*
  Types shared by the maintenance message issuer modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dvm_pkg;
    // message version selected by software
    typedef enum logic [1:0] {
        legacy_message_version = 2'h0,
        version_v8 = 2'h1,
        version_v8_1 = 2'h2,
        range_invalidate_version = 2'h3
    } dvm_version_e;

    // issue sequencer states, one-hot
    typedef enum logic [2:0] {
        st_idle = 3'h1,
        st_part1 = 3'h2,
        st_part2 = 3'h4
    } send_state_e;
endpackage

/* src/dvm_msg_if.sv */
/*
  Carrier between the register block, the field encoder and the
  read address channel sequencer. Assumes one clock domain.
*/
`timescale 1ns/1ns
interface dvm_msg_if;
    logic [31:0] msg_lo;
    logic [19:0] msg_hi;
    logic [31:0] addr_lo;
    logic [20:0] addr_hi;
    logic [15:0] range_cfg;
    dvm_pkg::dvm_version_e version;
    logic [47:0] part1;
    logic [3:0] ext1;
    logic [47:0] part2;
    logic [3:0] ext2;
    logic two_part;
    logic bad_stage;
    logic bad_type;
    logic start;
    logic busy;
    logic done;

    modport enc (
        input msg_lo, msg_hi, addr_lo, addr_hi, range_cfg, version,
        output part1, ext1, part2, ext2, two_part, bad_stage, bad_type
    );
    modport snd (
        input part1, ext1, part2, ext2, two_part, start,
        output busy, done
    );
    modport ctl (
        output msg_lo, msg_hi, addr_lo, addr_hi, range_cfg, version, start,
        input part1, ext1, part2, ext2, two_part, bad_stage, bad_type, busy, done
    );
endinterface

/* src/dvm_field_encoder.sv */
/*
  Builds both address-channel words of a maintenance message from the
  raw register fields. Purely combinational; assumes the register
  block holds the fields steady while a message is being started.
*/
`timescale 1ns/1ns
`include "dvm_defines.svh"
module dvm_field_encoder (
    dvm_msg_if.enc m
);
    // ==========================================================
    // field decode
    wire [2:0] msg_type = m.msg_lo[`F_TYPE_LSB +: 3];
    wire [1:0] stage = m.msg_lo[`F_STAGE_LSB +: 2];
    wire is_hint = (msg_type == `TYPE_HINT);
    wire is_tlbi = (msg_type == `TYPE_TLBI);
    wire two = m.msg_lo[`F_ADDR]; // RULE5
    wire asid_keep = m.msg_lo[`F_ASID_V] | is_hint; // RULE1
    wire vmid_keep = m.msg_lo[`F_VMID_V] | is_hint; // RULE18
    wire ext_ok = (m.version == dvm_pkg::version_v8_1) ||
                  (m.version == dvm_pkg::range_invalidate_version);
    // range only for a tlbi carrying an address, newest version
    wire range_ok = (m.version == dvm_pkg::range_invalidate_version) & is_tlbi & two; // RULE9
    wire range_on = range_ok & m.msg_lo[`F_RANGE]; // RULE10
    wire use_pa = (msg_type == `TYPE_PICI);
    wire [52:0] va = {m.addr_hi, m.addr_lo};
    wire [4:0] num = m.range_cfg[`RG_NUM_LSB +: 5];

    // ==========================================================
    // first part: unused bytes forced to zero, bit 1 always zero
    assign m.part1 = {m.msg_hi[15:0],
                      (vmid_keep ? m.msg_lo[31:24] : 8'h00), // RULE6
                      (asid_keep ? m.msg_lo[23:16] : 8'h00), // RULE1
                      m.msg_lo[15:8], // RULE16 RULE17
                      range_on, // RULE10
                      m.msg_lo[6:4], // RULE2
                      stage, // RULE3
                      1'b0, // RULE19
                      two};
    assign m.ext1 = (vmid_keep & ext_ok) ? m.msg_hi[19:16] : 4'h0; // RULE15

    // ==========================================================
    // second part: address layout, range fields in place of low bits
    wire [7:0] p2_top = use_pa ? va[47:40] : {va[52:49], va[44:41]}; // RULE7
    wire [7:0] p2_low = range_on ? {m.range_cfg[`RG_TG_LSB +: 2], // RULE11
                                    m.range_cfg[`RG_TTL_LSB +: 2], // RULE12
                                    m.range_cfg[`RG_SCALE_LSB +: 2], // RULE13
                                    num[4:3]} : va[11:4]; // RULE8 RULE14
    wire p2_b3 = use_pa ? 1'b0 : va[40]; // RULE7
    wire [2:0] p2_b20 = range_on ? num[2:0] : 3'h0; // RULE14
    assign m.part2 = two ? {p2_top, va[39:12], p2_low, p2_b3, p2_b20} : 48'h0000_0000_0000; // RULE6
    assign m.ext2 = (two & vmid_keep & ext_ok) ? m.range_cfg[`RG_EXT_LSB +: 4] : 4'h0;
    assign m.two_part = two;
    assign m.bad_stage = (stage == `STAGE_RSV); // RULE19
    assign m.bad_type = (msg_type == `TYPE_RSV_A) || (msg_type == `TYPE_RSV_B);
endmodule

/* src/dvm_ar_sender.sv */
/*
  Drives one or two read address beats of a maintenance message with a
  valid/ready handshake. Assumes start only arrives while not busy.
*/
`timescale 1ns/1ns
module dvm_ar_sender (
    input wire logic i_clock,
    input wire logic i_rst,
    dvm_msg_if.snd m,
    output logic o_ar_valid,
    output logic [47:0] o_ar_addr,
    output logic [3:0] o_ar_vmidext,
    input wire logic i_ar_ready
);
    dvm_pkg::send_state_e state_reg;
    dvm_pkg::send_state_e state_next;
    logic [47:0] p2_reg;
    logic [3:0] ext2_reg;
    logic two_reg;

    // ==========================================================
    // handshake decode
    wire beat_done = o_ar_valid & i_ar_ready;
    wire last_beat = beat_done & ((state_reg == dvm_pkg::st_part2) | ~two_reg);
    assign o_ar_valid = (state_reg != dvm_pkg::st_idle);
    assign m.busy = o_ar_valid;
    assign m.done = last_beat;

    // next state
    always_comb begin
        case (state_reg)
            dvm_pkg::st_idle: state_next = m.start ? dvm_pkg::st_part1 : dvm_pkg::st_idle;
            dvm_pkg::st_part1: begin
                if (!beat_done)
                    state_next = dvm_pkg::st_part1;
                else
                    state_next = two_reg ? dvm_pkg::st_part2 : dvm_pkg::st_idle; // RULE5
            end
            dvm_pkg::st_part2: state_next = beat_done ? dvm_pkg::st_idle : dvm_pkg::st_part2;
            default: state_next = dvm_pkg::st_idle;
        endcase
    end

    // words latched at start so register writes in flight do no harm
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= dvm_pkg::st_idle;
            o_ar_addr <= 48'h0000_0000_0000;
            o_ar_vmidext <= 4'h0;
            p2_reg <= 48'h0000_0000_0000;
            ext2_reg <= 4'h0;
            two_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (m.start && state_reg == dvm_pkg::st_idle) begin
                o_ar_addr <= m.part1; // RULE15
                o_ar_vmidext <= m.ext1;
                p2_reg <= m.part2;
                ext2_reg <= m.ext2;
                two_reg <= m.two_part;
            end else if (state_reg == dvm_pkg::st_part1 && beat_done && two_reg) begin
                o_ar_addr <= p2_reg; // RULE5
                o_ar_vmidext <= ext2_reg;
            end
        end
    end
endmodule

/* verification/dvm_ar_receiver.sv */
/*
  Receiver model for the read address channel of maintenance messages.
  Assumes one clock shared with the issuer and an active high reset.
*/
`timescale 1ns/1ns
module dvm_ar_receiver #(
    parameter bit legacy_rx = 1'b0
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire logic i_ar_valid,
    input wire logic [47:0] i_ar_addr,
    input wire logic [3:0] i_ar_vmidext,
    output logic o_ar_ready,
    output logic [7:0] o_msg_count
);
    // ========
    // acceptance and decode
    integer seed = 32'he274;
    logic second_reg;
    logic [1:0] stage_reg;
    logic [3:0] vmid_hi_reg;
    wire take = i_ar_valid && o_ar_ready;
    wire [1:0] stage = i_ar_addr[3:2];
    // random ready in slow mode tests beat hold
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_ar_ready <= 1'b0;
            second_reg <= 1'b0;
            stage_reg <= 2'h0;
            vmid_hi_reg <= 4'h0;
            o_msg_count <= 8'h00;
        end else begin
            o_ar_ready <= i_slow ? 1'($random(seed)) : 1'b1;
            if (take && second_reg) begin
                second_reg <= 1'b0;
                vmid_hi_reg <= i_ar_vmidext;
                o_msg_count <= o_msg_count + 8'h01;
            end else if (take) begin
                second_reg <= i_ar_addr[0];
                if (!i_ar_addr[0])
                    o_msg_count <= o_msg_count + 8'h01;
                // bit 1 ignored; a reserved stage must not corrupt state
                if (stage != 2'h3)
                    stage_reg <= (stage == 2'h0 && legacy_rx) ?
                        {i_ar_addr[6], !i_ar_addr[6]} : stage;
            end
        end
    end
endmodule

/* verification/dvm_host_checker.sv */
/*
  Port checker for the message issuer.
  Assumes it is bound onto dvm_host_ctrl.
*/
`timescale 1ns/1ns
module dvm_host_checker (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic o_ar_valid,
    input wire logic [47:0] o_ar_addr,
    input wire logic [3:0] o_ar_vmidext,
    input wire logic i_ar_ready
);
    // ========
    // part tracking
    logic second_reg;
    logic range_reg;
    wire take = o_ar_valid && i_ar_ready;
    wire first = o_ar_valid && !second_reg;
    wire hint = o_ar_addr[14:12] == 3'h6;
    // next beat is a second part only after a taken first part with bit 0
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            second_reg <= 1'b0;
            range_reg <= 1'b0;
        end else if (take) begin
            second_reg <= !second_reg && o_ar_addr[0];
            range_reg <= !second_reg && o_ar_addr[7];
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    sequence s_first_taken;
        first && i_ar_ready;
    endsequence
    sequence s_gap;
        !o_ar_valid;
    endsequence
    // ========
    // assertions
    hold_beat_a: assert property (
        o_ar_valid && !i_ar_ready |=> o_ar_valid && $stable(o_ar_addr) && $stable(o_ar_vmidext)
    ) else $error("beat changed before accept");
    two_part_a: assert property (
        s_first_taken ##0 o_ar_addr[0] |=> o_ar_valid && second_reg
    ) else $error("second part not sent next cycle");
    one_part_a: assert property (
        s_first_taken ##0 !o_ar_addr[0] |=> s_gap
    ) else $error("extra beat after one part message");
    part_gap_a: assert property (
        take && second_reg |=> s_gap
    ) else $error("no idle cycle after second part");
    asid_zero_a: assert property (
        first && !o_ar_addr[5] && !hint |-> o_ar_addr[23:16] == 8'h00
    ) else $error("asid byte not zero");
    vmid_zero_a: assert property (
        first && !o_ar_addr[6] && !hint |-> o_ar_addr[31:24] == 8'h00 && o_ar_vmidext == 4'h0
    ) else $error("vmid byte not zero");
    bit_one_a: assert property (
        first |-> !o_ar_addr[1] && o_ar_addr[3:2] != 2'h3
    ) else $error("reserved bit or stage sent");
    type_rsv_a: assert property (
        first |-> o_ar_addr[14:12] != 3'h5 && o_ar_addr[14:12] != 3'h7
    ) else $error("reserved type sent");
    range_tlbi_a: assert property (
        first && o_ar_addr[7] |-> o_ar_addr[14:12] == 3'h0 && o_ar_addr[0]
    ) else $error("range flag on wrong message");
    range_zero_a: assert property (
        o_ar_valid && second_reg && !range_reg |-> o_ar_addr[2:0] == 3'h0
    ) else $error("multiplier bits without range");
endmodule
bind dvm_host_ctrl dvm_host_checker i_chk (.i_clock(i_clock), .i_rst(i_rst),
    .o_ar_valid(o_ar_valid), .o_ar_addr(o_ar_addr), .o_ar_vmidext(o_ar_vmidext),
    .i_ar_ready(i_ar_ready));

/* verification/dvm_host_ctrl_tb.sv */
/*
  Self-checking bench for the message issuer.
  Assumes the receiver model and the checker are compiled first.
*/
`timescale 1ns/1ns
`include "dvm_defines.svh"
module dvm_host_ctrl_tb;
    logic i_clock, i_rst, i_avs_read, i_avs_write, i_ar_ready, o_ar_valid;
    logic o_avs_waitrequest, o_busy, slow;
    logic [3:0] i_avs_address, o_ar_vmidext;
    logic [31:0] i_avs_writedata, o_avs_readdata, lo, rd;
    logic [47:0] o_ar_addr;
    logic [7:0] msg_count;
    logic [51:0] beats[$];
    logic [3:0] regs[4] = '{`REG_CTRL, `REG_STATUS, `REG_COUNT, 4'hF};
    integer seed = 32'he274;
    int n_mismatch = 0;
    int n_checks = 0;
    dvm_host_ctrl i_dvm_host_ctrl (.i_clock(i_clock), .i_rst(i_rst),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .o_ar_valid(o_ar_valid),
        .o_ar_addr(o_ar_addr), .o_ar_vmidext(o_ar_vmidext), .i_ar_ready(i_ar_ready),
        .o_busy(o_busy));
    dvm_ar_receiver i_dvm_ar_receiver (.i_clock(i_clock), .i_rst(i_rst), .i_slow(slow),
        .i_ar_valid(o_ar_valid), .i_ar_addr(o_ar_addr), .i_ar_vmidext(o_ar_vmidext),
        .o_ar_ready(i_ar_ready), .o_msg_count(msg_count));
    // ========
    // clock and beat capture
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    always @(posedge i_clock)
        if (o_ar_valid === 1'b1 && i_ar_ready === 1'b1)
            beats.push_back({o_ar_vmidext, o_ar_addr});
    // ========
    // reporting
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [51:0] got, input logic [51:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one bus cycle; request held until waitrequest is seen low at an edge
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        for (n = 0; n < 400; n++) begin
            @(posedge i_clock);
            if (o_avs_waitrequest === 1'b0)
                break;
        end
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        if (n == 400) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    // ========
    // expected words, low 48 bits address, top 4 bits extension
    function automatic logic [51:0] exp_p1(logic [31:0] m, logic [19:0] h, logic [1:0] v);
        logic hn;
        logic [47:0] w;
        hn = m[14:12] == 3'h6;
        w = {h[15:0], m};
        if (!w[5] && !hn) w[23:16] = 8'h00;
        if (!w[6] && !hn) w[31:24] = 8'h00;
        w[1] = 1'b0;
        w[7] = w[7] && v == 2'h3 && w[14:12] == 3'h0 && w[0];
        return {(v < 2'h2 || (!w[6] && !hn)) ? 4'h0 : h[19:16], w};
    endfunction
    function automatic logic [51:0] exp_p2(logic [47:0] p, logic [52:0] a, logic [15:0] g,
        logic [1:0] v);
        logic pa;
        pa = p[14:12] == 3'h2;
        return {(v < 2'h2 || (!p[6] && p[14:12] != 3'h6)) ? 4'h0 : g[15:12],
            pa ? a[47:40] : {a[52:49], a[44:41]},
            a[39:12], p[7] ? {g[1:0], g[3:2], g[5:4], g[10:9]} : a[11:4],
            pa ? 1'b0 : a[40], p[7] ? g[8:6] : 3'h0};
    endfunction
    // ========
    // message scenarios
    task automatic send(input logic [31:0] m, input logic [19:0] h, input logic [52:0] a,
        input logic [15:0] g, input logic [1:0] v);
        logic [51:0] e1;
        int n;
        e1 = exp_p1(m, h, v);
        av(1'b1, `REG_MSG_LO, m);
        av(1'b1, `REG_MSG_HI, {12'h000, h});
        av(1'b1, `REG_ADDR_LO, a[31:0]);
        av(1'b1, `REG_ADDR_HI, {11'h000, a[52:32]});
        av(1'b1, `REG_RANGE, {16'h0000, g});
        av(1'b1, `REG_CTRL, {29'h0000_0000, v, 1'b1});
        // write while busy is held off
        if (slow)
            av(1'b1, `REG_MSG_LO, m);
        repeat (2) @(posedge i_clock);
        for (n = 0; n < 400 && o_busy !== 1'b0; n++)
            @(posedge i_clock);
        check(52'(n == 400), 52'h0, "busy stuck");
        if (n == 400)
            complete_run();
        check(52'(beats.size()), m[0] ? 52'h2 : 52'h1, "beat count");
        if (beats.size() > 0)
            check(beats[0], e1, "part one");
        if (beats.size() > 1)
            check(beats[1], exp_p2(e1[47:0], a, g, v), "part two");
        beats.delete();
    endtask
    task automatic bad(input logic [31:0] m, input int b);
        av(1'b1, `REG_MSG_LO, m);
        av(1'b1, `REG_CTRL, 32'h0000_0007);
        repeat (4) @(posedge i_clock);
        check(52'(beats.size()), 52'h0, "reserved code sent");
        av(1'b0, `REG_STATUS, 32'h0000_0000);
        check(52'(rd[b]), 52'h1, "error flag");
        av(1'b1, `REG_STATUS, 32'h0000_0001 << b);
        av(1'b0, `REG_STATUS, 32'h0000_0000);
        check(52'(rd[b]), 52'h0, "error flag clear");
    endtask
    initial begin
        i_rst = 1'b1;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_address = 4'h0;
        i_avs_writedata = 32'h0000_0000;
        slow = 1'b0;
        repeat (10) @(posedge i_clock);
        i_rst <= 1'b0;
        // reset values
        foreach (regs[i]) begin
            av(1'b0, regs[i], 32'h0000_0000);
            check(52'(rd), i == 0 ? 52'h6 : 52'h0, "reset value");
        end
        // every type, range, cleared flags, stalls
        for (int i = 0; i < 36; i++) begin
            lo = $random(seed);
            lo[14:12] = (i % 6 == 5) ? 3'h6 : 3'(i % 6);
            if (lo[3:2] == 2'h3)
                lo[3] = 1'b0;
            if (i % 4 == 0)
                lo[7] = 1'b1;
            if (i % 4 == 0)
                lo[0] = 1'b1;
            if (i % 5 == 1)
                lo[6:5] = 2'h0;
            slow <= i[0];
            send(lo, 20'($random(seed)), 53'({$random(seed), $random(seed)}),
                16'($random(seed)), (i % 4 == 0) ? 2'h3 : 2'($random(seed)));
        end
        bad(32'h0000_000D, 1);
        bad(32'h0000_5000, 2);
        bad(32'h0000_7000, 2);
        av(1'b0, `REG_COUNT, 32'h0000_0000);
        check(52'(rd), 52'h24, "message count");
        check(52'(msg_count), 52'h24, "receiver count");
        complete_run();
    end
endmodule
